/* pkg/srl_cfg.svh */
// Offsets, field positions, reset values and counts of the serial load front end
`ifndef SRL_CFG_SVH
`define SRL_CFG_SVH

// ---------------------------------------------------------------
// Word layout
// ---------------------------------------------------------------
`define SRL_WORD_W     24
`define SRL_SEL_W      4
`define SRL_NUM_REGS   8
`define SRL_BITCNT_W   5
`define SRL_SEL_MSB    3
`define SRL_SEL_LSB    0

// ---------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------
`define SRL_MAIN_IDX   0
`define SRL_TOC_IDX    6
`define SRL_EXT_IDX    7

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SRL_N_MSB      23
`define SRL_N_LSB      13
`define SRL_FN_MSB     12
`define SRL_FN_LSB     1
`define SRL_TOC_LSB    4
`define SRL_TOC_W      14

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SRL_WORD_RST   24'h000000
`define SRL_MASK_RST   8'h00

`endif

/* pkg/srl_pkg.sv */
// Types shared by the serial load front end
package srl_pkg;
`include "srl_cfg.svh"

   typedef logic [`SRL_WORD_W-1:0]   srl_word_t;
   typedef logic [`SRL_SEL_W-1:0]    srl_sel_t;
   typedef logic [`SRL_NUM_REGS-1:0] srl_onehot_t;
   typedef logic [`SRL_BITCNT_W-1:0] srl_bitcnt_t;
   typedef logic [`SRL_TOC_W-1:0]    srl_toc_t;

   typedef enum logic [1:0] {
      SRL_IDLE,
      SRL_SHIFT,
      SRL_COMMIT
   } srl_state_t;

endpackage

/* pkg/srl_link_if.sv */
// Signals passed between the pin sampler, the select decoder and the core
`timescale 1ns/1ps
interface srl_link_if;
   import srl_pkg::*;

   logic        sclk_rise;
   logic        sdata_lvl;
   logic        strobe_rise;
   logic        strobe_lvl;
   srl_sel_t    sel_field;
   srl_onehot_t sel_onehot;

   modport sync (output sclk_rise, output sdata_lvl, output strobe_rise, output strobe_lvl);
   modport dec  (input sel_field, output sel_onehot);
   modport core (input sclk_rise, input sdata_lvl, input strobe_rise, input strobe_lvl,
                 output sel_field, input sel_onehot);
endinterface

/* src/srl_pin_sync.sv */
// Two-stage synchroniser for the three serial pins, with rising-edge finders on the clock and strobe pins
`timescale 1ns/1ps
module srl_pin_sync
   import srl_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic ser_clk_pin,
   input  wire logic ser_data_pin,
   input  wire logic latch_load_strobe,
   srl_link_if.sync  lnk
);

   // ---------------------------------------------------------------
   // Synchroniser and edge history
   // ---------------------------------------------------------------
   logic [2:0] meta_q;
   logic [2:0] meta_d;
   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic [2:0] prev_q;
   logic [2:0] prev_d;

   always_comb
   begin
      meta_d = {latch_load_strobe, ser_data_pin, ser_clk_pin};
      sync_d = meta_q;
      prev_d = sync_q;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
         prev_q <= 3'h0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   // Data goes through the same two stages, so it stays aligned with the found edge
   assign lnk.sclk_rise   = sync_q[0] & ~prev_q[0];
   assign lnk.sdata_lvl   = sync_q[1];
   assign lnk.strobe_rise = sync_q[2] & ~prev_q[2];
   assign lnk.strobe_lvl  = sync_q[2];

endmodule // srl_pin_sync

/* src/srl_select_decode.sv */
// Decodes the low select field of a word into a one-hot latch target
`timescale 1ns/1ps
`include "srl_cfg.svh"
module srl_select_decode
   import srl_pkg::*;
(
   srl_link_if.dec lnk
);

   // ---------------------------------------------------------------
   // Decode function
   // ---------------------------------------------------------------
   function automatic srl_onehot_t srl_decode(input srl_sel_t sel);
      srl_onehot_t hot;
      hot = '0;
      if (!sel[0])
         hot[`SRL_MAIN_IDX] = 1'b1;
      else if (sel[3:1] != 3'h0)
         hot = srl_onehot_t'(8'h01 << sel[3:1]);
      // Select 0001 names no latch; the word is dropped
      return hot;
   endfunction

   assign lnk.sel_onehot = srl_decode(lnk.sel_field);

endmodule // srl_select_decode

/* src/srl_top.sv */
// Serial word loader and latch decoder of the dual synthesizer front end
//
// Function
// - Each transfer carries one 24-bit word that programs a divider or a mode latch.
// - Words arrive most significant bit first, so the last bits form the select field.
// - The shift register is copied into the chosen latch on the strobe's rising edge only.
// - The low bits of a word select the latch (four bits, or bit 0 alone for the main divider) and the rest are its data.
// - Select bit 0 low targets the main divider; with it high, codes 001 to 111 target 1 to 7.
// - Loading the main divider restarts the lock detector and the fast-lock counters.
// - That restart clears only those counters and leaves every programmed latch unchanged.
// - The main divider uses a single select bit, leaving 23 data bits for one-word retune.
`timescale 1ns/1ps
`include "srl_cfg.svh"
module srl_top
   import srl_pkg::*;
(
   input  wire logic                      core_clk,
   input  wire logic                      sys_rst,
   input  wire logic                      ser_clk_pin,
   input  wire logic                      ser_data_pin,
   input  wire logic                      latch_load_strobe,
   output logic [`SRL_WORD_W-1:0]         rf_main_divider_word,
   output logic [`SRL_WORD_W-1:0]         rf_reference_divider_word,
   output logic [`SRL_WORD_W-1:0]         aux_main_divider_word,
   output logic [`SRL_WORD_W-1:0]         aux_reference_divider_word,
   output logic [`SRL_WORD_W-1:0]         output_select_oscillator_word,
   output logic [`SRL_WORD_W-1:0]         extended_fraction_word,
   output logic [`SRL_WORD_W-1:0]         fast_lock_timeout_word,
   output logic [`SRL_WORD_W-1:0]         counter_reset_test_word,
   output logic [`SRL_N_MSB-`SRL_N_LSB:0]   rf_integer_divider_value,
   output logic [`SRL_FN_MSB-`SRL_FN_LSB:0] rf_fraction_numerator,
   output logic                           word_loaded,
   output logic [`SRL_SEL_W-1:0]          last_select,
   output logic [`SRL_NUM_REGS-1:0]       loaded_mask,
   output logic                           short_word,
   output logic                           order_warning,
   output logic                           lock_restart,
   output logic                           fastlock_active
);

   // ---------------------------------------------------------------
   // Pin sampling and select decode
   // ---------------------------------------------------------------
   srl_link_if lnk ();

   srl_pin_sync u_sync (
      .core_clk          (core_clk),
      .sys_rst           (sys_rst),
      .ser_clk_pin       (ser_clk_pin),
      .ser_data_pin      (ser_data_pin),
      .latch_load_strobe (latch_load_strobe),
      .lnk               (lnk.sync)
   );

   srl_select_decode u_dec (
      .lnk (lnk.dec)
   );

   // ---------------------------------------------------------------
   // Shift path and sequencing
   // ---------------------------------------------------------------
   srl_state_t  state_q;
   srl_state_t  state_d;
   srl_word_t   shift_q;
   srl_word_t   shift_d;
   srl_bitcnt_t bits_q;
   srl_bitcnt_t bits_d;
   srl_word_t   held_q;
   srl_word_t   held_d;
   srl_onehot_t target_q;
   srl_onehot_t target_d;
   logic        full_q;
   logic        full_d;

   assign lnk.sel_field = shift_q[`SRL_SEL_MSB:`SRL_SEL_LSB];

   always_comb
   begin
      state_d  = state_q;
      shift_d  = shift_q;
      bits_d   = bits_q;
      held_d   = held_q;
      target_d = target_q;
      full_d   = full_q;
      case (state_q)
         SRL_IDLE:
         begin
            // Clock edges while the strobe is high are not data
            if (lnk.sclk_rise && !lnk.strobe_lvl)
            begin
               shift_d = {shift_q[`SRL_WORD_W-2:0], lnk.sdata_lvl};
               bits_d  = srl_bitcnt_t'(1);
               state_d = SRL_SHIFT;
            end
         end
         SRL_SHIFT:
         begin
            if (lnk.strobe_rise)
            begin
               held_d   = shift_q;
               target_d = lnk.sel_onehot;
               full_d   = (bits_q >= srl_bitcnt_t'(`SRL_WORD_W));
               state_d  = SRL_COMMIT;
            end
            else if (lnk.sclk_rise && !lnk.strobe_lvl)
            begin
               // Only the newest 24 bits are kept; earlier ones fall off the top
               shift_d = {shift_q[`SRL_WORD_W-2:0], lnk.sdata_lvl};
               if (bits_q < srl_bitcnt_t'(`SRL_WORD_W))
                  bits_d = bits_q + srl_bitcnt_t'(1);
            end
         end
         SRL_COMMIT:
         begin
            bits_d  = '0;
            state_d = SRL_IDLE;
         end
         default:
         begin
            bits_d  = '0;
            state_d = SRL_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state_q  <= SRL_IDLE;
         shift_q  <= `SRL_WORD_RST;
         bits_q   <= '0;
         held_q   <= `SRL_WORD_RST;
         target_q <= '0;
         full_q   <= 1'b0;
      end
      else
      begin
         state_q  <= state_d;
         shift_q  <= shift_d;
         bits_q   <= bits_d;
         held_q   <= held_d;
         target_q <= target_d;
         full_q   <= full_d;
      end
   end

   // ---------------------------------------------------------------
   // Control latches
   // ---------------------------------------------------------------
   srl_word_t   latch_q [`SRL_NUM_REGS];
   srl_word_t   latch_d [`SRL_NUM_REGS];
   logic        commit;
   logic        main_hit;

   assign commit   = (state_q == SRL_COMMIT);
   assign main_hit = commit && target_q[`SRL_MAIN_IDX];

   always_comb
   begin
      for (int i = 0; i < `SRL_NUM_REGS; i++)
      begin
         latch_d[i] = latch_q[i];
         // Latches hold their contents until the commit cycle of a strobe edge
         if (commit && target_q[i])
            latch_d[i] = held_q;
      end
   end

   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < `SRL_NUM_REGS; i++)
      begin
         if (sys_rst)
            latch_q[i] <= `SRL_WORD_RST;
         else
            latch_q[i] <= latch_d[i];
      end
   end

   assign rf_main_divider_word          = latch_q[0];
   assign rf_reference_divider_word     = latch_q[1];
   assign aux_main_divider_word         = latch_q[2];
   assign aux_reference_divider_word    = latch_q[3];
   assign output_select_oscillator_word = latch_q[4];
   assign extended_fraction_word        = latch_q[5];
   assign fast_lock_timeout_word        = latch_q[6];
   assign counter_reset_test_word       = latch_q[7];

   // Main divider fields come from the single-select-bit layout
   assign rf_integer_divider_value = latch_q[`SRL_MAIN_IDX][`SRL_N_MSB:`SRL_N_LSB];
   assign rf_fraction_numerator    = latch_q[`SRL_MAIN_IDX][`SRL_FN_MSB:`SRL_FN_LSB];

   // ---------------------------------------------------------------
   // Load status
   // ---------------------------------------------------------------
   logic                    loaded_q;
   logic                    loaded_d;
   srl_sel_t                sel_q;
   srl_sel_t                sel_d;
   srl_onehot_t             mask_q;
   srl_onehot_t             mask_d;
   logic                    short_q;
   logic                    short_d;
   logic                    warn_q;
   logic                    warn_d;

   always_comb
   begin
      loaded_d = commit && (target_q != '0);
      sel_d    = sel_q;
      mask_d   = mask_q | (commit ? target_q : '0);
      short_d  = short_q;
      warn_d   = warn_q;
      if (commit)
      begin
         sel_d   = held_q[`SRL_SEL_MSB:`SRL_SEL_LSB];
         short_d = !full_q;
         // Another latch written after the main divider leaves counters on stale settings
         if (main_hit)
            warn_d = 1'b0;
         else if (mask_q[`SRL_MAIN_IDX] && (target_q != '0))
            warn_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         loaded_q <= 1'b0;
         sel_q    <= '0;
         mask_q   <= `SRL_MASK_RST;
         short_q  <= 1'b0;
         warn_q   <= 1'b0;
      end
      else
      begin
         loaded_q <= loaded_d;
         sel_q    <= sel_d;
         mask_q   <= mask_d;
         short_q  <= short_d;
         warn_q   <= warn_d;
      end
   end

   assign word_loaded   = loaded_q;
   assign last_select   = sel_q;
   // Bit five may legally stay clear when extended resolution is unused
   assign loaded_mask   = mask_q;
   assign short_word    = short_q;
   assign order_warning = warn_q;

   // ---------------------------------------------------------------
   // Lock detect and fast-lock restart
   // ---------------------------------------------------------------
   logic     restart_q;
   logic     restart_d;
   srl_toc_t fl_count_q;
   srl_toc_t fl_count_d;
   srl_toc_t fl_limit;
   logic     fl_run_q;
   logic     fl_run_d;

   assign fl_limit = latch_q[`SRL_TOC_IDX][`SRL_TOC_LSB+`SRL_TOC_W-1:`SRL_TOC_LSB];

   always_comb
   begin
      restart_d  = main_hit;
      fl_count_d = fl_count_q;
      fl_run_d   = fl_run_q;
      // Only the counters are cleared; no latch is touched by the restart
      if (main_hit)
      begin
         fl_count_d = '0;
         fl_run_d   = (fl_limit != '0);
      end
      else if (fl_run_q)
      begin
         if (fl_count_q + srl_toc_t'(1) >= fl_limit)
            fl_run_d = 1'b0;
         fl_count_d = fl_count_q + srl_toc_t'(1);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         restart_q  <= 1'b0;
         fl_count_q <= '0;
         fl_run_q   <= 1'b0;
      end
      else
      begin
         restart_q  <= restart_d;
         fl_count_q <= fl_count_d;
         fl_run_q   <= fl_run_d;
      end
   end

   assign lock_restart    = restart_q;
   assign fastlock_active = fl_run_q;

endmodule // srl_top

/* bench/srl_top_props.sv */
// Concurrent checks on the serial load front end ports
`timescale 1ns/1ps
module srl_top_props
(
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        latch_load_strobe,
   input wire logic [23:0] rf_main_divider_word,
   input wire logic [23:0] rf_reference_divider_word,
   input wire logic [23:0] fast_lock_timeout_word,
   input wire logic [10:0] rf_integer_divider_value,
   input wire logic [11:0] rf_fraction_numerator,
   input wire logic        word_loaded,
   input wire logic [3:0]  last_select,
   input wire logic        lock_restart,
   input wire logic        fastlock_active
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // ---------------------------------------------------------------
   // Sequences
   // ---------------------------------------------------------------
   sequence s_main_commit;
      word_loaded && lock_restart;
   endsequence
   sequence s_fastlock_three;
      fastlock_active[*3] ##1 !fastlock_active;
   endsequence

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_main_change_pulse: assert property ($changed(rf_main_divider_word) |-> s_main_commit)
      else $error("main divider changed without a commit");
   a_ref_load_only: assert property ($changed(rf_reference_divider_word)
      |-> word_loaded && !lock_restart)
      else $error("reference divider changed without its commit");
   a_restart_keeps_regs: assert property (lock_restart
      |-> $stable(rf_reference_divider_word) && $stable(fast_lock_timeout_word))
      else $error("restart disturbed a programmed latch");
   a_restart_single: assert property (lock_restart |-> word_loaded ##1 !lock_restart)
      else $error("restart pulse malformed");
   a_divider_fields: assert property (word_loaded
      |-> rf_integer_divider_value == rf_main_divider_word[23:13]
      && rf_fraction_numerator == rf_main_divider_word[12:1])
      else $error("divider fields disagree with main word");
   // Pin sampled high four edges back and low five back is the rise that was committed
   a_load_after_strobe: assert property (word_loaded
      |-> $past(latch_load_strobe, 4) && !$past(latch_load_strobe, 5))
      else $error("commit without a strobe rise");
   a_select_decode: assert property (word_loaded |-> lock_restart == !last_select[0])
      else $error("select low bit and restart disagree");
   a_fastlock_run: assert property (lock_restart
      && fast_lock_timeout_word[17:4] == 14'h0003 |-> s_fastlock_three)
      else $error("fast-lock window length wrong");
   a_fastlock_zero: assert property (lock_restart
      && fast_lock_timeout_word[17:4] == 14'h0000 |-> !fastlock_active)
      else $error("fast-lock ran with zero limit");
endmodule // srl_top_props

bind srl_top srl_top_props u_props (
   .core_clk                  (core_clk),
   .sys_rst                   (sys_rst),
   .latch_load_strobe         (latch_load_strobe),
   .rf_main_divider_word      (rf_main_divider_word),
   .rf_reference_divider_word (rf_reference_divider_word),
   .fast_lock_timeout_word    (fast_lock_timeout_word),
   .rf_integer_divider_value  (rf_integer_divider_value),
   .rf_fraction_numerator     (rf_fraction_numerator),
   .word_loaded               (word_loaded),
   .last_select               (last_select),
   .lock_restart              (lock_restart),
   .fastlock_active           (fastlock_active)
);

/* bench/srl_host_model.sv */
// Behavioural host that shifts words into the three serial pins
`timescale 1ns/1ps
module srl_host_model
   import srl_pkg::*;
(
   input  wire logic core_clk,
   output logic      ser_clk_pin,
   output logic      ser_data_pin,
   output logic      latch_load_strobe
);
   // Link clock stands low between frames, 320 ns period within them
   initial
   begin
      ser_clk_pin       = 1'b0;
      ser_data_pin      = 1'b0;
      latch_load_strobe = 1'b0;
   end

   task automatic half_period();
      repeat (4) @(negedge core_clk);
   endtask

   task automatic shift_bit(input logic b);
      ser_data_pin = b;
      half_period();
      ser_clk_pin = 1'b1;
      half_period();
      ser_clk_pin = 1'b0;
   endtask

   task automatic strobe();
      latch_load_strobe = 1'b1;
      half_period();
      latch_load_strobe = 1'b0;
      half_period();
   endtask

   task automatic send(input srl_word_t w, input bit with_strobe);
      for (int i = 23; i >= 0; i--)
         shift_bit(w[i]);
      // Released data line shows the inverse, never the last bit
      ser_data_pin = ~ser_data_pin;
      half_period();
      if (with_strobe)
         strobe();
   endtask
endmodule // srl_host_model

/* bench/tb.sv */
// Self-checking bench for the serial load front end
`timescale 1ns/1ps
module tb;
   import srl_pkg::*;
   logic             core_clk = 1'b0;
   logic             sys_rst  = 1'b1;
   wire logic        ser_clk_pin, ser_data_pin, latch_load_strobe;
   wire logic [23:0] lat [0:7];
   wire logic [10:0] int_val;
   wire logic [11:0] frac_val;
   wire logic        word_loaded, order_warning, lock_restart, fastlock_active, short_word;
   wire logic [3:0]  last_select;
   wire logic [7:0]  loaded_mask;
   srl_word_t        model [0:7];
   int               errors = 0, checked = 0, cycles = 0, n_load = 0, n_rst = 0, n_fl = 0;

   always #20 core_clk = ~core_clk;

   srl_host_model u_host (.core_clk(core_clk), .ser_clk_pin(ser_clk_pin),
      .ser_data_pin(ser_data_pin), .latch_load_strobe(latch_load_strobe));

   srl_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .ser_clk_pin(ser_clk_pin),
      .ser_data_pin(ser_data_pin), .latch_load_strobe(latch_load_strobe),
      .rf_main_divider_word(lat[0]), .rf_reference_divider_word(lat[1]),
      .aux_main_divider_word(lat[2]), .aux_reference_divider_word(lat[3]),
      .output_select_oscillator_word(lat[4]), .extended_fraction_word(lat[5]),
      .fast_lock_timeout_word(lat[6]), .counter_reset_test_word(lat[7]),
      .rf_integer_divider_value(int_val), .rf_fraction_numerator(frac_val),
      .word_loaded(word_loaded), .last_select(last_select), .loaded_mask(loaded_mask),
      .short_word(short_word), .order_warning(order_warning), .lock_restart(lock_restart),
      .fastlock_active(fastlock_active));

   // ---------------------------------------------------------------
   // Monitor, timeout and reporting
   // ---------------------------------------------------------------
   // Pulses arrive while the host is still busy, so they are counted here on settled values
   always @(negedge core_clk)
   begin
      cycles++;
      if (word_loaded === 1'b1) n_load++;
      if (lock_restart === 1'b1) n_rst++;
      if (fastlock_active === 1'b1) n_fl++;
      if (cycles == 20000)
      begin
         errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic wr(input srl_word_t w);
      int l0, r0;
      l0 = n_load;
      r0 = n_rst;
      u_host.send(w, 1'b1);
      repeat (4) @(negedge core_clk);
      if (w[3:0] !== 4'h1)
         model[w[0] ? w[3:1] : 3'h0] = w;
      for (int i = 0; i < 8; i++) check("latch", lat[i], model[i]);
      check("loads", n_load, l0 + (w[3:0] !== 4'h1));
      check("restart", n_rst, r0 + !w[0]);
      check("select", last_select, w[3:0]);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      int f0;
      for (int i = 0; i < 8; i++) model[i] = 24'h000000;
      repeat (2) @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge core_clk);
      for (int i = 0; i < 8; i++) check("reset", lat[i], 24'h000000);
      for (int k = 1; k < 8; k++) wr({20'hC3A50 + 20'(k), k[2:0], 1'b1});
      check("order", order_warning, 1'b0);
      wr(24'h00003D);
      f0 = n_fl;
      wr(24'hABCDEE);
      check("int", int_val, 11'h55E);
      check("frac", frac_val, 12'h6F7);
      check("fastlock", n_fl - f0, 3);
      wr(24'h111115);
      check("order", order_warning, 1'b1);
      wr(24'h246800);
      check("order", order_warning, 1'b0);
      u_host.send(24'h123457, 1'b0);
      check("held", lat[3], model[3]);
      u_host.strobe();
      repeat (4) @(negedge core_clk);
      check("strobed", lat[3], 24'h123457);
      model[3] = 24'h123457;
      for (int i = 0; i < 4; i++) u_host.shift_bit(1'b1);
      wr(24'h654325);
      wr(24'hFFFFF1);
      check("mask", loaded_mask, 8'hFF);
      // Four bits after a commit: the older twenty bits stay in the shift register
      for (int i = 3; i >= 0; i--) u_host.shift_bit(i == 3 || i == 0);
      u_host.strobe();
      repeat (4) @(negedge core_clk);
      check("short", short_word, 1'b1);
      check("partial", lat[4], 24'hFFFF19);
      model[4] = 24'hFFFF19;
      wr(24'h00000D);
      f0 = n_fl;
      wr(24'h13579A);
      check("fastlock", n_fl - f0, 0);
      check("short", short_word, 1'b0);
      report_and_stop();
   end
endmodule // tb
